// File: src/bank_output_state.sv
// One bank's output-kind holder.
// Assumes write strobe and command are from the same clock domain.
`timescale 1ns/1ns
module bank_output_state (
    input wire logic core_clk_i, // Clock
    input wire logic rst_i, // Sync reset, active high
    input wire logic hit_i, // Command write aimed at this bank
    input wire logic [fcsm_pkg::CMD_W-1:0] cmd_i, // Command code
    output fcsm_pkg::out_kind_t kind_o // Output kind of this bank
);
    import fcsm_pkg::*;

    // ----------------------------------------
    // Output kind register
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            kind_o <= OUT_ARRAY;
        end else if (hit_i) begin
            case (cmd_i)
                CMD_READ_ARRAY: kind_o <= OUT_ARRAY;
                CMD_READ_STATUS: kind_o <= OUT_STATUS;
                CMD_READ_SIG: kind_o <= OUT_SIGNATURE;
                CMD_READ_QUERY: kind_o <= OUT_QUERY;
                CMD_PROG_SETUP, CMD_BUF_SETUP, CMD_CONFIRM,
                CMD_LOCK_SETUP, CMD_OTP_SETUP: kind_o <= OUT_STATUS;
                default: kind_o <= kind_o;
            endcase
        end
    end

    a_bank_hold: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !hit_i |=> kind_o == $past(kind_o))
        else $error("bank output kind changed without a command");
    a_bank_status: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        hit_i && cmd_i == CMD_READ_STATUS |=> kind_o == OUT_STATUS)
        else $error("read status did not select status output");
endmodule // bank_output_state

// File: src/fcsm_pkg.sv
// Package: command codes, state and output-kind enumerations.
// Assumes an 8-bit command field and a bank-number field from the bus side.
package fcsm_pkg;
    localparam int CMD_W = 8;
    localparam int CNT_W = 8;
    localparam logic [CMD_W-1:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [CMD_W-1:0] CMD_OTP_SETUP = 8'hC0;
    localparam logic [CMD_W-1:0] CMD_BLK_LOCK = 8'h01;
    localparam logic [CMD_W-1:0] CMD_BLK_LOCKDOWN = 8'h2F;
    localparam logic [CMD_W-1:0] CMD_SET_SETUP_WORD = 8'h03;
    localparam logic [CMD_W-1:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [CMD_W-1:0] CMD_BUF_SETUP = 8'hE8;
    localparam logic [CMD_W-1:0] CMD_CONFIRM = 8'hD0;
    localparam logic [CMD_W-1:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [CMD_W-1:0] CMD_READ_STATUS = 8'h70;
    localparam logic [CMD_W-1:0] CMD_READ_SIG = 8'h90;
    localparam logic [CMD_W-1:0] CMD_READ_QUERY = 8'h98;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    typedef enum logic [1:0] {
        OUT_ARRAY,
        OUT_STATUS,
        OUT_SIGNATURE,
        OUT_QUERY
    } out_kind_t;

    typedef enum logic [3:0] {
        ST_READY,
        ST_LOCK_SETUP,
        ST_OTP_SETUP,
        ST_OTP_BUSY,
        ST_INTERIM_OTP,
        ST_PROG_SETUP,
        ST_PROG_BUSY,
        ST_INTERIM_PROG,
        ST_BUF_SETUP,
        ST_BUF_LOAD1,
        ST_BUF_LOAD2,
        ST_BUF_CONFIRM,
        ST_BUF_BUSY,
        ST_INTERIM_BUF,
        ST_INTERIM_READY
    } front_state_t;
endpackage

// File: src/flash_bank_command_state_machine.sv
// Command front end of a multi-bank flash: decodes command cycles and
// tracks program controller busy; per-bank output kind selection.
// Assumes writes and controller done arrive on core_clk_i, one cycle each.
// Behaviour
// - At reset every bank presents array data.
// - A bank keeps its output kind until a command hits that bank.
// - Output kind set by a command affects only the addressed bank.
// - Output kind is array, status, signature or query data.
// - Next state uses current state, write strobe, command, count and done, not output kind.
// - While controller is active, two-cycle command cycles are discarded.
// - After buffer setup, count minus one is latched; go to load 1.
// - Load 2 takes words, decrementing count; confirm expected at zero.
// - Program busy plus lock setup enters interim; program continues.
// - Buffer busy plus setup enters interim; done goes to interim ready.
`timescale 1ns/1ns
module flash_bank_command_state_machine #(
    parameter int BANKS = 16, // Number of banks
    parameter int BANK_W = 4 // Bank number width
) (
    input wire logic core_clk_i, // Clock, 100 MHz
    input wire logic rst_i, // Sync reset, active high
    input wire logic wr_i, // Command write strobe, one cycle
    input wire logic [fcsm_pkg::CMD_W-1:0] cmd_i, // Command or data low
    input wire logic [BANK_W-1:0] bank_i, // Bank of the write address
    input wire logic [BANK_W-1:0] rd_bank_i, // Bank of the read address
    input wire logic pec_done_i, // Controller finished, one cycle
    output fcsm_pkg::front_state_t state_o, // Current interface state
    output fcsm_pkg::out_kind_t rd_kind_o, // Output kind for read bank
    output logic pec_start_o, // Start controller, one-cycle pulse
    output logic pec_busy_o, // Controller running
    output logic lock_err_o, // Sticky lock error
    output logic lock_op_o, // Lock or set-word confirm pulse
    output logic buf_word_o, // Buffer data word accepted pulse
    output logic [fcsm_pkg::CNT_W-1:0] count_o // Remaining word count
);
    import fcsm_pkg::*;

    front_state_t state_r;
    front_state_t state_nxt;
    logic [CNT_W-1:0] count_nxt;
    logic [BANK_W-1:0] cmd_bank_r;
    out_kind_t kind_w [BANKS];
    logic start_nxt;
    logic lock_bad;
    logic lock_ok;

    // ----------------------------------------
    // Per-bank output kind
    // ----------------------------------------
    for (genvar g = 0; g < BANKS; g++) begin : g_bank
        bank_output_state bank_output_state_inst (
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .hit_i(wr_i && bank_i == BANK_W'(g)),
            .cmd_i(cmd_i),
            .kind_o(kind_w[g])
        );
    end

    // Read mux registered to keep outputs from flip-flops
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_kind_o <= OUT_ARRAY;
        end else begin
            rd_kind_o <= kind_w[rd_bank_i];
        end
    end

    // ----------------------------------------
    // Next-state decode
    // ----------------------------------------
    // Only state_r, wr_i, cmd_i, count_o and pec_done_i are read here, never a bank kind
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_o;
        start_nxt = 1'b0;
        lock_bad = 1'b0;
        lock_ok = 1'b0;
        case (state_r)
            ST_READY, ST_INTERIM_READY: begin
                if (wr_i) begin
                    case (cmd_i)
                        CMD_LOCK_SETUP: state_nxt = ST_LOCK_SETUP;
                        CMD_OTP_SETUP: state_nxt = ST_OTP_SETUP;
                        CMD_PROG_SETUP: state_nxt = ST_PROG_SETUP;
                        CMD_BUF_SETUP: state_nxt = ST_BUF_SETUP;
                        default: state_nxt = ST_READY;
                    endcase
                end
            end
            ST_LOCK_SETUP: begin
                if (wr_i) begin
                    state_nxt = ST_READY;
                    if (cmd_i == CMD_BLK_LOCK || cmd_i == CMD_BLK_LOCKDOWN ||
                        cmd_i == CMD_SET_SETUP_WORD) begin
                        lock_ok = 1'b1;
                    end else begin
                        lock_bad = 1'b1;
                    end
                end
            end
            ST_OTP_SETUP: begin
                if (wr_i) begin
                    state_nxt = ST_OTP_BUSY;
                    start_nxt = 1'b1;
                end
            end
            ST_PROG_SETUP: begin
                if (wr_i) begin
                    state_nxt = ST_PROG_BUSY;
                    start_nxt = 1'b1;
                end
            end
            ST_BUF_SETUP: begin
                if (wr_i) begin
                    state_nxt = ST_BUF_LOAD1;
                    count_nxt = cmd_i;
                end
            end
            ST_BUF_LOAD1: begin
                if (wr_i) begin
                    // First word location; count keeps the words still due
                    if (count_o == CNT_ZERO) begin
                        state_nxt = ST_BUF_CONFIRM;
                    end else begin
                        state_nxt = ST_BUF_LOAD2;
                    end
                end
            end
            ST_BUF_LOAD2: begin
                if (wr_i) begin
                    if (count_o == CNT_ONE) begin
                        state_nxt = ST_BUF_CONFIRM;
                    end
                    count_nxt = count_o - CNT_ONE;
                end
            end
            ST_BUF_CONFIRM: begin
                if (wr_i) begin
                    if (cmd_i == CMD_CONFIRM) begin
                        state_nxt = ST_BUF_BUSY;
                        start_nxt = 1'b1;
                    end else begin
                        state_nxt = ST_READY;
                    end
                end
            end
            // Busy states: writes ignored except setup entering interim
            ST_OTP_BUSY, ST_PROG_BUSY, ST_BUF_BUSY: begin
                if (pec_done_i) begin
                    state_nxt = ST_READY;
                end else if (wr_i && cmd_i == CMD_LOCK_SETUP) begin
                    if (state_r == ST_OTP_BUSY) begin
                        state_nxt = ST_INTERIM_OTP;
                    end else if (state_r == ST_PROG_BUSY) begin
                        state_nxt = ST_INTERIM_PROG;
                    end else begin
                        state_nxt = ST_INTERIM_BUF;
                    end
                end
            end
            ST_INTERIM_OTP, ST_INTERIM_PROG, ST_INTERIM_BUF: begin
                if (pec_done_i) begin
                    state_nxt = ST_INTERIM_READY;
                end else if (wr_i) begin
                    // Second cycle discarded, back to plain busy
                    case (state_r)
                        ST_INTERIM_OTP: state_nxt = ST_OTP_BUSY;
                        ST_INTERIM_PROG: state_nxt = ST_PROG_BUSY;
                        default: state_nxt = ST_BUF_BUSY;
                    endcase
                end
            end
            default: state_nxt = ST_READY;
        endcase
    end

    // ----------------------------------------
    // State and counter registers
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_r <= ST_READY;
            count_o <= CNT_ZERO;
        end else begin
            state_r <= state_nxt;
            count_o <= count_nxt;
        end
    end

    assign state_o = state_r;

    // Controller handshake and event pulses
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pec_start_o <= 1'b0;
            pec_busy_o <= 1'b0;
            lock_op_o <= 1'b0;
            buf_word_o <= 1'b0;
        end else begin
            pec_start_o <= start_nxt;
            if (start_nxt) begin
                pec_busy_o <= 1'b1;
            end else if (pec_done_i) begin
                pec_busy_o <= 1'b0;
            end
            lock_op_o <= lock_ok;
            buf_word_o <= wr_i && (state_r == ST_BUF_LOAD1 ||
                state_r == ST_BUF_LOAD2);
        end
    end

    // Sticky lock error, cleared by a new lock setup from ready
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            lock_err_o <= 1'b0;
        end else if (lock_bad) begin
            lock_err_o <= 1'b1;
        end else if (wr_i && cmd_i == CMD_LOCK_SETUP &&
                     state_r == ST_READY) begin
            lock_err_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_busy_ignore: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        state_r == ST_PROG_BUSY && wr_i && cmd_i != CMD_LOCK_SETUP &&
        !pec_done_i |=> state_r == ST_PROG_BUSY)
        else $error("program busy left on a non-setup write");
    a_busy_interim: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        state_r == ST_PROG_BUSY && wr_i && cmd_i == CMD_LOCK_SETUP &&
        !pec_done_i |=> state_r == ST_INTERIM_PROG)
        else $error("program busy did not enter interim");
    a_interim_done: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        state_r == ST_INTERIM_BUF && pec_done_i |=>
        state_r == ST_INTERIM_READY)
        else $error("interim buffer busy did not go to interim ready");
    a_count_latch: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        state_r == ST_BUF_SETUP && wr_i |=>
        state_r == ST_BUF_LOAD1 && count_o == $past(cmd_i))
        else $error("buffer count not latched");
    a_load_dec: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        state_r == ST_BUF_LOAD2 && wr_i |=>
        count_o == $past(count_o) - CNT_ONE)
        else $error("buffer count not decremented");
    a_load_end: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        state_r == ST_BUF_LOAD2 && wr_i && count_o == CNT_ONE |=>
        state_r == ST_BUF_CONFIRM)
        else $error("load did not end at zero count");
    a_lock_error: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        state_r == ST_LOCK_SETUP && wr_i && cmd_i != CMD_BLK_LOCK &&
        cmd_i != CMD_BLK_LOCKDOWN && cmd_i != CMD_SET_SETUP_WORD |=>
        state_r == ST_READY && lock_err_o)
        else $error("bad lock confirm not flagged");
    a_otp_flow: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        state_r == ST_OTP_SETUP && wr_i |=>
        state_r == ST_OTP_BUSY && pec_start_o)
        else $error("otp write did not start controller");
    a_busy_noop: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        state_r == ST_BUF_BUSY && wr_i && !pec_done_i |=>
        !pec_start_o && !lock_op_o)
        else $error("write acted while controller active");
    a_read_kind: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        1'b1 |=> rd_kind_o == $past(kind_w[rd_bank_i]))
        else $error("read kind not from read bank");
    c_buf_prog: cover property (@(posedge core_clk_i) disable iff (rst_i)
        state_r == ST_BUF_CONFIRM ##1 state_r == ST_BUF_BUSY);
    c_lock_ok: cover property (@(posedge core_clk_i) disable iff (rst_i)
        lock_op_o);
    c_interim_ready: cover property (@(posedge core_clk_i)
        disable iff (rst_i) state_r == ST_INTERIM_READY);
endmodule // flash_bank_command_state_machine

// File: tb/flash_bank_command_state_machine_tb.sv
// Self-checking bench for the flash command front end.
// Assumes host_model drives the write side; reads only compare kinds.
`timescale 1ns/1ns
module flash_bank_command_state_machine_tb;
    import fcsm_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] rd_bank_i = 4'h0;
    logic wr_i, pec_done_i;
    logic [7:0] cmd_i, count_o;
    logic [3:0] bank_i;
    front_state_t state_o;
    out_kind_t rd_kind_o;
    logic pec_start_o, pec_busy_o, lock_err_o, lock_op_o, buf_word_o;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // Clock, partner and block
    // ------------------------------------------------------------
    always #5 core_clk_i = ~core_clk_i;

    host_model host_model_inst (.core_clk_i(core_clk_i), .wr_o(wr_i),
        .cmd_o(cmd_i), .bank_o(bank_i), .done_o(pec_done_i));

    flash_bank_command_state_machine flash_bank_command_state_machine_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .wr_i(wr_i), .cmd_i(cmd_i),
        .bank_i(bank_i), .rd_bank_i(rd_bank_i), .pec_done_i(pec_done_i),
        .state_o(state_o), .rd_kind_o(rd_kind_o), .pec_start_o(pec_start_o),
        .pec_busy_o(pec_busy_o), .lock_err_o(lock_err_o),
        .lock_op_o(lock_op_o), .buf_word_o(buf_word_o), .count_o(count_o));

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic summarize();
        $display("errors %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic chk_st(input front_state_t e);
        chk({4'h0, state_o}, {4'h0, e});
    endtask

    task automatic w(input logic [7:0] c, input logic [3:0] b);
        host_model_inst.issue(c, b);
    endtask

    // Cut a hang short
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk_st(ST_READY);
        chk({6'h0, rd_kind_o}, {6'h0, OUT_ARRAY});
        chk({7'h0, pec_busy_o}, 8'h00);
        chk(count_o, 8'h00);
    endtask

    // Each read code sets bank 2 only; bank 3 stays array
    task automatic t_kinds();
        logic [7:0] codes [4] = '{8'h70, 8'h90, 8'h98, 8'hFF};
        out_kind_t kinds [4] = '{OUT_STATUS, OUT_SIGNATURE, OUT_QUERY,
            OUT_ARRAY};
        for (int i = 0; i < 4; i++) begin
            w(codes[i], 4'h2);
            rd_bank_i = 4'h2;
            @(posedge core_clk_i);
            #1;
            chk({6'h0, rd_kind_o}, {6'h0, kinds[i]});
            rd_bank_i = 4'h3;
            repeat (2) @(posedge core_clk_i);
            #1;
            chk({6'h0, rd_kind_o}, {6'h0, OUT_ARRAY});
        end
        w(8'h98, 4'h1); // Leave bank 1 in query for the lock sequence
    endtask

    // Every confirm code, then a bad second cycle
    task automatic t_lock();
        logic [7:0] codes [3] = '{8'h01, 8'h2F, 8'h03};
        for (int i = 0; i < 3; i++) begin
            w(CMD_LOCK_SETUP, 4'h1);
            chk_st(ST_LOCK_SETUP);
            w(codes[i], 4'h1);
            chk_st(ST_READY);
            chk({7'h0, lock_op_o}, 8'h01);
            chk({7'h0, lock_err_o}, 8'h00);
        end
        w(CMD_LOCK_SETUP, 4'h1);
        w(8'h55, 4'h1);
        chk_st(ST_READY);
        chk({7'h0, lock_err_o}, 8'h01);
        // Lock setup left bank 1 on status; confirm cycles kept it
        rd_bank_i = 4'h1;
        @(posedge core_clk_i);
        #1;
        chk({6'h0, rd_kind_o}, {6'h0, OUT_STATUS});
    endtask

    // Program busy ignores pairs, interim on setup, done to ready
    task automatic t_prog();
        w(CMD_PROG_SETUP, 4'h5);
        w(8'h12, 4'h5);
        chk_st(ST_PROG_BUSY);
        chk({6'h0, pec_start_o, pec_busy_o}, 8'h03);
        w(CMD_LOCK_SETUP, 4'h5);
        chk_st(ST_INTERIM_PROG);
        w(CMD_BLK_LOCK, 4'h5);
        chk_st(ST_PROG_BUSY);
        chk({6'h0, lock_op_o, pec_start_o}, 8'h00);
        // Array read to the busy bank; its data is never looked at
        w(CMD_READ_ARRAY, 4'h5);
        chk_st(ST_PROG_BUSY);
        host_model_inst.done();
        @(posedge core_clk_i);
        #1;
        chk_st(ST_READY);
        chk({7'h0, pec_busy_o}, 8'h00);
    endtask

    task automatic t_otp();
        w(CMD_OTP_SETUP, 4'h6);
        chk_st(ST_OTP_SETUP);
        w(8'h34, 4'h6);
        chk_st(ST_OTP_BUSY);
        chk({7'h0, pec_start_o}, 8'h01);
        host_model_inst.done();
        chk_st(ST_READY);
    endtask

    // Four-word buffer, interim during busy, bad confirm afterwards
    task automatic t_buf();
        w(CMD_BUF_SETUP, 4'h4);
        chk_st(ST_BUF_SETUP);
        w(8'h03, 4'h4);
        chk_st(ST_BUF_LOAD1);
        chk(count_o, 8'h03);
        w(8'hAA, 4'h4);
        chk_st(ST_BUF_LOAD2);
        chk({7'h0, buf_word_o}, 8'h01);
        chk(count_o, 8'h03);
        // Exactly three more words; only the last leaves the load phase
        for (int i = 0; i < 3; i++) begin
            w(8'h5A, 4'h4);
            chk({7'h0, buf_word_o}, 8'h01);
            chk(count_o, 8'h02 - 8'(i));
            if (i < 2) begin
                chk_st(ST_BUF_LOAD2);
            end
        end
        chk_st(ST_BUF_CONFIRM);
        chk(count_o, 8'h00);
        w(CMD_CONFIRM, 4'h4);
        chk_st(ST_BUF_BUSY);
        w(CMD_LOCK_SETUP, 4'h4);
        chk_st(ST_INTERIM_BUF);
        host_model_inst.done();
        chk_st(ST_INTERIM_READY);
        w(CMD_BUF_SETUP, 4'h4);
        w(8'h00, 4'h4);
        w(8'h77, 4'h4);
        chk_st(ST_BUF_CONFIRM);
        w(8'h55, 4'h4);
        chk_st(ST_READY);
        chk({7'h0, pec_start_o}, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk_i);
        #1;
        rst_i = 1'b0;
        t_reset();
        t_kinds();
        t_lock();
        t_prog();
        t_otp();
        t_buf();
        summarize();
    end
endmodule // flash_bank_command_state_machine_tb

// File: tb/host_model.sv
// Host model: issues command write cycles and controller done pulses.
// Assumes the block samples its inputs on the rising edge of core_clk_i.
`timescale 1ns/1ns
module host_model (
    input wire logic core_clk_i, // Clock
    output logic wr_o, // Write strobe, one cycle
    output logic [7:0] cmd_o, // Command, count or data
    output logic [3:0] bank_o, // Bank of the write address
    output logic done_o // Controller finished pulse
);
    // Idle bus at time zero
    initial begin
        wr_o = 1'b0;
        cmd_o = 8'hA5;
        bank_o = 4'hA;
        done_o = 1'b0;
    end

    // One bus write; callers keep both cycles of a pair on one bank
    task automatic issue(input logic [7:0] c, input logic [3:0] b);
        @(posedge core_clk_i);
        #1;
        wr_o = 1'b1;
        cmd_o = c;
        bank_o = b;
        @(posedge core_clk_i);
        #1;
        wr_o = 1'b0;
        cmd_o = ~c; // Released bus never shows the last value
        bank_o = ~b;
    endtask

    // Controller completion, one cycle wide
    task automatic done();
        @(posedge core_clk_i);
        #1;
        done_o = 1'b1;
        @(posedge core_clk_i);
        #1;
        done_o = 1'b0;
    endtask
endmodule // host_model
